// ===== powerup_reset_selftest.sv
// Power-on initialisation pulse, LED control, boot remap and ROM and memory self-test.
`default_nettype none
// Overview of operation
// RQ1: Hold initialisation low 100 ms at power-up.
// RQ2: Keep initialisation asserted while supply not good.
// RQ3: All five LEDs lit during initialisation.
// RQ4: After release blink LEDs, remap boot ROM high.
// RQ5: Truncated 8-bit ROM sum matches last byte.
// RQ6: Pass one clears every longword.
// RQ7: Pass two checks zeroes, writes, checks ones.
// RQ8: Pass three ones, 55, AA, zero checks.
// RQ9: Fixed order; only first error reported.
// RQ10: Errors shown on LEDs and reported.
// RQ11: All pass lights green, idle until mouse.
// RQ12: Supply good synchronised; counter times interval.
module powerup_reset_selftest #(
  parameter int INIT_COUNT = powerup_pkg::INIT_CYCLES,
  parameter int ROM_AW = powerup_pkg::ROM_AW,
  parameter int MEM_AW = powerup_pkg::MEM_AW,
  parameter int BLINK_CYCLES = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic supplyGood,
  input wire logic mouseButton,
  output logic [ROM_AW-1:0] romAddr,
  input wire logic [7:0] romData,
  output powerup_pkg::mem_req_s memReq,
  input wire logic [31:0] memRdata,
  input wire logic memAck,
  output logic boardInit_n,
  output logic [4:0] leds,
  output logic bootRomHigh,
  output powerup_pkg::err_rep_s errReport,
  output logic idleState
);
  localparam logic [ROM_AW-1:0] ROM_LAST = {ROM_AW{1'b1}};
  localparam logic [MEM_AW-1:0] MEM_LAST = {MEM_AW{1'b1}};

  logic syncA_r;
  logic syncB_r;
  logic [31:0] initCnt_r;
  logic [31:0] blinkCnt_r;
  powerup_pkg::seq_e state_r;
  logic [ROM_AW-1:0] romPtr_r;
  logic [7:0] romSum_r;
  logic [MEM_AW-1:0] memPtr_r;
  logic [2:0] step_r;
  logic errFlag_r;
  logic memBusy_r;

  // Expected read value and write value for each step of passes two and three.
  function automatic logic [31:0] stepData(input logic p3, input logic [2:0] s);
    if (!p3) begin
      stepData = (s == 3'h1) ? powerup_pkg::PAT_ONES : (s == 3'h2 ? powerup_pkg::PAT_ONES : powerup_pkg::PAT_ZERO);
    end else begin
      unique case (s)
        3'h0: stepData = powerup_pkg::PAT_ONES;
        3'h1, 3'h2: stepData = powerup_pkg::PAT_FIVE;
        3'h3, 3'h4: stepData = powerup_pkg::PAT_AAAA;
        default: stepData = powerup_pkg::PAT_ZERO;
      endcase
    end
  endfunction

  // Two-flop synchroniser; supply good is asynchronous to the board clock.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      syncA_r <= 1'b0;
      syncB_r <= 1'b0;
    end else begin
      syncA_r <= supplyGood; // [RQ12]
      syncB_r <= syncA_r; // [RQ12]
    end
  end

  // Interval counter restarts whenever the supply drops out, so a brown-out gets a full pulse.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      initCnt_r <= '0;
    end else if (!syncB_r) begin
      initCnt_r <= '0; // [RQ2]
    end else if (initCnt_r < 32'(INIT_COUNT)) begin
      initCnt_r <= initCnt_r + 32'h1; // [RQ1] [RQ12]
    end
  end

  // Initialisation output; held while counting or while the supply is bad.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      boardInit_n <= 1'b0;
    end else begin
      boardInit_n <= syncB_r && (initCnt_r >= 32'(INIT_COUNT)); // [RQ1] [RQ2]
    end
  end

  // Main sequencer. Returns to init whenever initialisation is reasserted.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_r <= powerup_pkg::ST_INIT;
      blinkCnt_r <= '0;
      romPtr_r <= '0;
      romSum_r <= 8'h00;
      memPtr_r <= '0;
      step_r <= 3'h0;
      errFlag_r <= 1'b0;
      memBusy_r <= 1'b0;
      bootRomHigh <= 1'b0;
      leds <= powerup_pkg::LED_ALL;
      errReport <= '0;
      memReq <= '0;
      romAddr <= '0;
      idleState <= 1'b0;
    end else if (!boardInit_n) begin
      state_r <= powerup_pkg::ST_INIT;
      leds <= powerup_pkg::LED_ALL; // [RQ3]
      bootRomHigh <= 1'b0;
      blinkCnt_r <= '0;
      errFlag_r <= 1'b0;
      memReq <= '0;
      memBusy_r <= 1'b0;
      errReport <= '0;
      idleState <= 1'b0;
    end else begin
      errReport.valid <= 1'b0;
      unique case (state_r)
        powerup_pkg::ST_INIT: begin
          state_r <= powerup_pkg::ST_BLINK;
          leds <= powerup_pkg::LED_OFF; // [RQ4]
          blinkCnt_r <= '0;
        end
        powerup_pkg::ST_BLINK: begin
          blinkCnt_r <= blinkCnt_r + 32'h1;
          if (blinkCnt_r == 32'(BLINK_CYCLES)) begin
            leds <= powerup_pkg::LED_ALL; // [RQ4]
            bootRomHigh <= 1'b1; // [RQ4] The blink access remaps the boot ROM.
            state_r <= powerup_pkg::ST_ROM;
            romPtr_r <= '0;
            romAddr <= '0;
            romSum_r <= 8'h00;
          end
        end
        powerup_pkg::ST_ROM: begin
          // ROM data is taken one cycle after the address is presented.
          romAddr <= romPtr_r;
          state_r <= powerup_pkg::ST_ROM_WAIT;
        end
        powerup_pkg::ST_ROM_WAIT: begin
          if (romPtr_r == ROM_LAST) begin
            state_r <= powerup_pkg::ST_ROM_CMP;
          end else begin
            romSum_r <= romSum_r + romData; // [RQ5] Sum wraps, giving the 8-bit truncation.
            romPtr_r <= romPtr_r + 1'b1;
            state_r <= powerup_pkg::ST_ROM;
          end
        end
        powerup_pkg::ST_ROM_CMP: begin
          memPtr_r <= '0;
          state_r <= powerup_pkg::ST_CLR;
          if (romSum_r != romData) begin
            errFlag_r <= 1'b1; // [RQ5] [RQ9]
            leds <= powerup_pkg::LED_ROM_ERR; // [RQ10]
            errReport <= '{valid: 1'b1, code: powerup_pkg::ERR_ROM, addr: 16'h0000}; // [RQ10]
          end
        end
        powerup_pkg::ST_CLR, powerup_pkg::ST_P2, powerup_pkg::ST_P3: begin
          if (errFlag_r) begin
            state_r <= powerup_pkg::ST_FAIL; // [RQ9] Skip diagnostics after a prior error.
          end else if (!memBusy_r) begin
            memBusy_r <= 1'b1;
            memReq.req <= 1'b1;
            memReq.addr <= 16'(memPtr_r);
            if (state_r == powerup_pkg::ST_CLR) begin
              memReq.wr <= 1'b1; // [RQ6]
              memReq.wdata <= powerup_pkg::PAT_ZERO; // [RQ6]
            end else begin
              // Even steps read, odd steps write, in both later passes.
              memReq.wr <= step_r[0]; // [RQ7] [RQ8]
              memReq.wdata <= stepData(state_r == powerup_pkg::ST_P3, step_r); // [RQ7] [RQ8]
            end
          end else if (memAck) begin
            memReq.req <= 1'b0;
            memBusy_r <= 1'b0;
            if (state_r != powerup_pkg::ST_CLR && !memReq.wr &&
                memRdata != stepData(state_r == powerup_pkg::ST_P3, step_r)) begin
              errFlag_r <= 1'b1; // [RQ9]
              leds <= powerup_pkg::LED_MEM_ERR; // [RQ10]
              errReport <= '{valid: 1'b1, code: powerup_pkg::ERR_MEM, addr: 16'(memPtr_r)}; // [RQ10]
            end else if (state_r == powerup_pkg::ST_CLR || step_r == (state_r == powerup_pkg::ST_P3 ? 3'h6 : 3'h2)) begin
              step_r <= 3'h0;
              memPtr_r <= memPtr_r + 1'b1;
              if (memPtr_r == MEM_LAST) begin
                unique case (state_r)
                  powerup_pkg::ST_CLR: state_r <= powerup_pkg::ST_P2; // [RQ7]
                  powerup_pkg::ST_P2: state_r <= powerup_pkg::ST_P3; // [RQ8]
                  default: state_r <= powerup_pkg::ST_DONE;
                endcase
              end
            end else begin
              step_r <= step_r + 3'h1;
            end
          end
        end
        powerup_pkg::ST_DONE: begin
          leds <= powerup_pkg::LED_GREEN; // [RQ11]
          state_r <= powerup_pkg::ST_IDLE;
        end
        powerup_pkg::ST_IDLE: begin
          idleState <= !mouseButton; // [RQ11]
        end
        powerup_pkg::ST_FAIL: begin
          idleState <= 1'b0;
        end
        default: state_r <= powerup_pkg::ST_FAIL;
      endcase
    end
  end

  // Checks.
  initPulse_a: assert property (@(posedge clk_sys) disable iff (reset)
    (!syncB_r) |=> ##1 !boardInit_n) else $error("Init released while supply bad."); // [RQ2]
  ledsInit_a: assert property (@(posedge clk_sys) disable iff (reset)
    (!boardInit_n && !$past(boardInit_n)) |=> leds == powerup_pkg::LED_ALL) else $error("LEDs not all on."); // [RQ3]
  remapAfter_a: assert property (@(posedge clk_sys) disable iff (reset)
    (!boardInit_n) |=> !bootRomHigh) else $error("Remap during init."); // [RQ4]
  firstErr_a: assert property (@(posedge clk_sys) disable iff (reset)
    (errFlag_r && boardInit_n) |=> !errReport.valid) else $error("Second error reported."); // [RQ9]
  greenPass_a: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == powerup_pkg::ST_IDLE) |-> leds == powerup_pkg::LED_GREEN) else $error("Green not lit."); // [RQ11]
  clearWrite_a: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == powerup_pkg::ST_CLR && memReq.req) |-> memReq.wr && memReq.wdata == 32'h0) else $error("Bad clear."); // [RQ6]

  // Named steps of the release, the ROM fetch and the memory handshake.
  sequence initRelease;
    $rose(boardInit_n);
  endsequence
  sequence romFetch;
    (state_r == powerup_pkg::ST_ROM) ##1 (state_r == powerup_pkg::ST_ROM_WAIT);
  endsequence
  sequence memTake;
    memReq.req ##1 memReq.req;
  endsequence

  // The second stage only ever copies the first, so nothing else sees a metastable value.
  syncStage_a: assert property (@(posedge clk_sys) disable iff (reset)
    syncB_r == $past(syncA_r)) else $error("Synchroniser stage skipped."); // [RQ12]

  // The counter saturates; a runaway count would wrap and reassert initialisation.
  initCap_a: assert property (@(posedge clk_sys) disable iff (reset)
    initCnt_r <= 32'(INIT_COUNT)) else $error("Init counter overran."); // [RQ1]

  // Release comes only after the full interval.
  initLength_a: assert property (@(posedge clk_sys) disable iff (reset)
    initRelease |-> $past(initCnt_r) == 32'(INIT_COUNT)) else $error("Init pulse short."); // [RQ1]

  // The blink starts with the LEDs dark right after release.
  blinkOff_a: assert property (@(posedge clk_sys) disable iff (reset)
    initRelease |=> leds == powerup_pkg::LED_OFF) else $error("Blink not dark."); // [RQ4]

  // The remap coincides with the LEDs coming back on.
  remapLeds_a: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(bootRomHigh) |-> leds == powerup_pkg::LED_ALL) else $error("Remap without blink."); // [RQ4]

  // Any initialisation, including a brown-out, lights every LED.
  initLeds_a: assert property (@(posedge clk_sys) disable iff (reset)
    (!boardInit_n) |=> leds == powerup_pkg::LED_ALL) else $error("LEDs dark in init."); // [RQ3]

  // Each ROM byte gets its address cycle before it is summed.
  romStep_a: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == powerup_pkg::ST_ROM && boardInit_n) |-> romFetch) else $error("ROM fetch skipped."); // [RQ5]

  // The byte summed is the one the pointer names.
  romAddr_a: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == powerup_pkg::ST_ROM_WAIT) |-> romAddr == romPtr_r) else $error("ROM address stale."); // [RQ5]

  // A request is held until the memory acknowledges it.
  reqHold_a: assert property (@(posedge clk_sys) disable iff (reset)
    (memReq.req && !memAck && boardInit_n) |-> memTake) else $error("Request dropped."); // [RQ6]

  // Address and direction do not move under a pending request.
  reqStable_a: assert property (@(posedge clk_sys) disable iff (reset)
    (memReq.req && !memAck && boardInit_n) |=> $stable(memReq.addr) && $stable(memReq.wr)) else $error("Request moved."); // [RQ6]

  // Pass two only ever writes all ones.
  passTwoWrite_a: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == powerup_pkg::ST_P2 && memReq.req && memReq.wr) |-> memReq.wdata == powerup_pkg::PAT_ONES) else $error("Bad pass two."); // [RQ7]

  // The first write of pass three is the first checkerboard.
  passThreeFive_a: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == powerup_pkg::ST_P3 && memReq.req && memReq.wr && step_r == 3'h1) |-> memReq.wdata == powerup_pkg::PAT_FIVE) else $error("Bad checkerboard."); // [RQ8]

  // A ROM error report shows its own LED code.
  romErrLed_a: assert property (@(posedge clk_sys) disable iff (reset)
    (errReport.valid && errReport.code == powerup_pkg::ERR_ROM) |-> leds == powerup_pkg::LED_ROM_ERR) else $error("ROM LED wrong."); // [RQ10]

  // A memory error report shows its own LED code.
  memErrLed_a: assert property (@(posedge clk_sys) disable iff (reset)
    (errReport.valid && errReport.code == powerup_pkg::ERR_MEM) |-> leds == powerup_pkg::LED_MEM_ERR) else $error("Memory LED wrong."); // [RQ10]

  // Idle is reached only with a clean record.
  idleClean_a: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == powerup_pkg::ST_IDLE) |-> !errFlag_r) else $error("Idle after error."); // [RQ9]
endmodule
`default_nettype wire

// ===== powerup_pkg.sv
// Package with constants, states and carrier structs for the power-up sequencer.
`default_nettype none
package powerup_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int INIT_MS = 100;
  localparam int INIT_CYCLES = (CLK_HZ / 1000) * INIT_MS;
  localparam int ROM_AW = 14;
  localparam int MEM_AW = 16;
  localparam int BOOT_LOW_BASE = 24'h000000;
  localparam int BOOT_HIGH_BASE = 24'h180000;
  localparam logic [31:0] PAT_ZERO = 32'h00000000;
  localparam logic [31:0] PAT_ONES = 32'hffffffff;
  localparam logic [31:0] PAT_FIVE = 32'h55555555;
  localparam logic [31:0] PAT_AAAA = 32'haaaaaaaa;
  localparam logic [4:0] LED_ALL = 5'h1f;
  localparam logic [4:0] LED_OFF = 5'h00;
  localparam logic [4:0] LED_GREEN = 5'h01;
  localparam logic [4:0] LED_ROM_ERR = 5'h02;
  localparam logic [4:0] LED_MEM_ERR = 5'h04;
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_ROM = 3'h1;
  localparam logic [2:0] ERR_MEM = 3'h2;

  // Sequencer states, one-hot.
  typedef enum logic [10:0] {
    ST_INIT = 11'h001,
    ST_BLINK = 11'h002,
    ST_ROM = 11'h004,
    ST_ROM_CMP = 11'h008,
    ST_CLR = 11'h010,
    ST_P2 = 11'h020,
    ST_P3 = 11'h040,
    ST_DONE = 11'h080,
    ST_IDLE = 11'h100,
    ST_FAIL = 11'h200,
    ST_ROM_WAIT = 11'h400
  } seq_e;

  // Program memory request toward the memory.
  typedef struct packed {
    logic req;
    logic wr;
    logic [15:0] addr;
    logic [31:0] wdata;
  } mem_req_s;

  // Error report to the host processor.
  typedef struct packed {
    logic valid;
    logic [2:0] code;
    logic [15:0] addr;
  } err_rep_s;
endpackage
`default_nettype wire

// ===== mem_rom_model.sv
// Behavioural boot ROM and program memory standing on the far side of the sequencer.
`default_nettype none
module mem_rom_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic badRom,
  input wire logic faultOn,
  input wire logic [2:0] romAddr,
  output logic [7:0] romData,
  input wire powerup_pkg::mem_req_s memReq,
  output logic [31:0] memRdata,
  output logic memAck,
  output int nWrites
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] FAULT_ADDR = 3'h5;
  logic [31:0] mem [8];
  logic [31:0] lastData;
  // Bytes 0 to 6 hold multiples of 11h; the last byte holds their 8-bit sum, or a wrong value on command.
  // The ROM answers within the cycle, so the byte stands at the next edge as the sequencer expects.
  assign romData = (romAddr == 3'h7) ? (badRom ? 8'h5a : 8'hdc) : 8'h11 * ({5'h00, romAddr} + 8'h01);
  // One-cycle acknowledge; the memory starts with junk so that a skipped clear pass shows up.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      memAck <= 1'b0;
      nWrites <= 0;
      lastData <= 32'h00000000;
      for (int i = 0; i < 8; i++) mem[i] <= 32'h12345678;
    end else begin
      memAck <= memReq.req & ~memAck;
      if (memReq.req && !memAck && memReq.wr) begin
        mem[memReq.addr[2:0]] <= memReq.wdata;
        nWrites <= nWrites + 1;
      end
      if (memReq.req && !memAck && !memReq.wr) begin
        lastData <= mem[memReq.addr[2:0]] | {31'h0, faultOn && memReq.addr[2:0] == FAULT_ADDR};
      end
    end
  end
  // Outside the acknowledge the data lines show the inverse, so stale data is never mistaken for valid.
  assign memRdata = memAck ? lastData : ~lastData;
endmodule
`default_nettype wire

// ===== test_powerup_reset_selftest.sv
// Self-checking bench for the power-up sequencer with its ROM and memory model.
`default_nettype none
module test_powerup_reset_selftest;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INITC = 50;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic supplyGood = 1'b1;
  logic mouseButton = 1'b0;
  logic badRom = 1'b0;
  logic faultOn = 1'b0;
  logic [2:0] romAddr;
  logic [7:0] romData;
  powerup_pkg::mem_req_s memReq;
  logic [31:0] memRdata;
  logic memAck;
  logic boardInit_n;
  logic [4:0] leds;
  logic bootRomHigh;
  powerup_pkg::err_rep_s errReport;
  logic idleState;
  int nWrites;
  int n_errors = 0;
  int n_compared = 0;
  int errCnt = 0;
  logic [2:0] errCode = 3'h0;
  logic [15:0] errAddr = 16'h0000;
  powerup_reset_selftest #(.INIT_COUNT(INITC), .ROM_AW(3), .MEM_AW(3), .BLINK_CYCLES(16)) dut (
    .clk_sys(clk_sys), .reset(reset), .supplyGood(supplyGood), .mouseButton(mouseButton),
    .romAddr(romAddr), .romData(romData), .memReq(memReq), .memRdata(memRdata), .memAck(memAck),
    .boardInit_n(boardInit_n), .leds(leds), .bootRomHigh(bootRomHigh), .errReport(errReport),
    .idleState(idleState));
  mem_rom_model model (.clk_sys(clk_sys), .reset(reset), .badRom(badRom), .faultOn(faultOn),
    .romAddr(romAddr), .romData(romData), .memReq(memReq), .memRdata(memRdata), .memAck(memAck),
    .nWrites(nWrites));
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Error pulses last one cycle, so they are caught on every edge and kept.
  always @(posedge clk_sys) begin
    if (reset) begin
      errCnt <= 0;
      errCode <= 3'h0;
      errAddr <= 16'h0000;
    end else if (errReport.valid === 1'b1) begin
      errCnt <= errCnt + 1;
      errCode <= errReport.code;
      errAddr <= errReport.addr;
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic restart(input logic romBad, input logic fault);
    @(negedge clk_sys);
    reset = 1'b1;
    badRom = romBad;
    faultOn = fault;
    mouseButton = 1'b0;
    supplyGood = 1'b1;
    repeat (4) @(negedge clk_sys);
    reset = 1'b0;
  endtask
  // Bounded wait for either the idle state or a reported error, then let the outputs settle.
  task automatic wait_end();
    for (int i = 0; i < 3000 && idleState !== 1'b1 && errCnt == 0; i++) @(negedge clk_sys);
    repeat (5) @(negedge clk_sys);
  endtask
  task automatic test_init_and_pass();
    int t;
    restart(1'b0, 1'b0);
    repeat (INITC - 2) @(negedge clk_sys);
    chk("boardInit_n early", 32'h0, boardInit_n);
    chk("leds during init", 32'h1f, leds);
    chk("boot map during init", 32'h0, bootRomHigh);
    for (t = INITC - 2; t < INITC + 20 && boardInit_n !== 1'b1; t++) @(negedge clk_sys);
    chk("init release time", 32'h1, t >= INITC && t <= INITC + 4);
    repeat (2) @(negedge clk_sys);
    chk("leds blink off", 32'h0, leds);
    repeat (18) @(negedge clk_sys);
    chk("leds blink on", 32'h1f, leds);
    chk("boot map high", 32'h1, bootRomHigh);
    wait_end();
    chk("idle reached", 32'h1, idleState);
    chk("green led", 32'h01, leds);
    chk("no error", 32'h0, errCnt);
    chk("write count", 32'd40, nWrites);
    for (int i = 0; i < 8; i++) chk("final longword", 32'h0, model.mem[i]);
    mouseButton = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("idle left on mouse", 32'h0, idleState);
  endtask
  task automatic test_supply_drop();
    restart(1'b0, 1'b0);
    repeat (INITC + 30) @(negedge clk_sys);
    supplyGood = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk("init on supply loss", 32'h0, boardInit_n);
    chk("leds on supply loss", 32'h1f, leds);
    repeat (INITC + 10) @(negedge clk_sys);
    chk("init held while bad", 32'h0, boardInit_n);
    supplyGood = 1'b1;
    wait_end();
    chk("idle after recovery", 32'h1, idleState);
  endtask
  task automatic test_rom_error();
    restart(1'b1, 1'b1);
    wait_end();
    chk("rom error code", 32'h1, errCode);
    chk("rom error leds", 32'h02, leds);
    chk("memory passes skipped", 32'h0, nWrites);
    chk("no idle after rom error", 32'h0, idleState);
  endtask
  task automatic test_mem_error();
    restart(1'b0, 1'b1);
    wait_end();
    chk("mem error code", 32'h2, errCode);
    chk("mem error address", 32'h5, errAddr);
    chk("mem error leds", 32'h04, leds);
    chk("single report", 32'h1, errCnt);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    test_init_and_pass();
    test_supply_drop();
    test_rom_error();
    test_mem_error();
    finish_test();
  end
  // Four runs of a few hundred cycles each fit well inside this span.
  initial begin
    #200000;
    n_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
